// ### rtl/psu_sig_ctrl.sv
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ns
module psu_sig_ctrl
  import psu_sig_pkg::*;
#(
  parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = FAST_HALF_CYC,
  parameter int unsigned HOLDUP    = HOLDUP_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hot_unplug_kill,
  input  wire logic        main_output_enable_n,
  input  wire logic        input_ok_raw,
  input  wire logic        share_largest,
  input  wire mon_t        mon_raw,
  output logic             main_output_on,
  output logic             standby_on,
  output logic             power_good,
  output logic             input_in_range,
  output logic             fault_alert_n,
  output logic             present_n,
  output logic             fan_full_speed,
  output logic             share_bus_pin_connect,
  output logic             share_master,
  output logic      [9:0]  share_trim_mv,
  output logic             led_green,
  output logic             led_amber
);

  if (SLOW_HALF < 2 || FAST_HALF < 2 || HOLDUP < 1) begin : g_bad_param
    $error("psu_sig_ctrl: counts too small");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [3:0] pin_s1_r, pin_s2_r;
  mon_t       mon_s1_r, mon_s_r;
  logic       kill_s, en_n_s, in_ok_s, largest_s;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1_r <= 4'h4;
      pin_s2_r <= 4'h4;
      mon_s1_r <= '0;
      mon_s_r  <= '0;
    end else begin
      pin_s1_r <= {hot_unplug_kill, main_output_enable_n, input_ok_raw, share_largest};
      pin_s2_r <= pin_s1_r;
      mon_s1_r <= mon_raw;
      mon_s_r  <= mon_s1_r;
    end
  end

  assign {kill_s, en_n_s, in_ok_s, largest_s} = pin_s2_r;

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave
  logic [2:0]  ctrl_r, ctrl_nxt;
  logic [8:0]  inlet_r, inlet_nxt;
  logic [9:0]  trim_req_r, trim_req_nxt;
  logic [31:0] prdata_nxt;
  logic        pready_nxt, pslverr_nxt, acc, hit;
  logic [31:0] status_w, fault_w;
  latch_t      latch_r, latch_nxt;
  led_t        led_r, led_nxt;
  logic        warn_any, shutdown_nxt;

  always_comb begin
    acc          = psel && penable && !pready;
    ctrl_nxt     = ctrl_r;
    inlet_nxt    = inlet_r;
    trim_req_nxt = trim_req_r;
    prdata_nxt   = '0;
    pready_nxt   = acc;
    pslverr_nxt  = 1'b0;
    hit          = 1'b1;
    unique case (paddr)
      ADDR_CTRL:   prdata_nxt = {29'h0, ctrl_r};
      ADDR_INLET:  prdata_nxt = {23'h0, inlet_r};
      ADDR_TRIM:   prdata_nxt = {22'h0, trim_req_r};
      ADDR_STATUS: prdata_nxt = status_w;
      ADDR_FAULT:  prdata_nxt = fault_w;
      default:     hit = 1'b0;
    endcase
    if (acc) begin
      pslverr_nxt = !hit;
      if (pwrite) begin
        prdata_nxt = '0;
        if (paddr == ADDR_CTRL)  ctrl_nxt     = pwdata[2:0];
        if (paddr == ADDR_INLET) inlet_nxt    = pwdata[8:0];
        if (paddr == ADDR_TRIM)  trim_req_nxt = pwdata[9:0];
      end
    end else begin
      prdata_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_r     <= CTRL_RST;
      inlet_r    <= INLET_RST;
      trim_req_r <= TRIM_RST;
      prdata     <= '0;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      inlet_r    <= inlet_nxt;
      trim_req_r <= trim_req_nxt;
      prdata     <= prdata_nxt;
      pready     <= pready_nxt;
      pslverr    <= pslverr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // blink divider and holdup timer
  logic [31:0] slow_cnt_r, slow_cnt_nxt, fast_cnt_r, fast_cnt_nxt;
  logic [31:0] holdup_cnt_r, holdup_cnt_nxt;
  logic        slow_ph_r, slow_ph_nxt, fast_ph_r, fast_ph_nxt, holdup_exp;

  always_comb begin
    slow_cnt_nxt = slow_cnt_r + 32'h1;
    slow_ph_nxt  = slow_ph_r;
    if (slow_cnt_r == SLOW_HALF - 1) begin
      slow_cnt_nxt = '0;
      slow_ph_nxt  = !slow_ph_r;
    end
    fast_cnt_nxt = fast_cnt_r + 32'h1;
    fast_ph_nxt  = fast_ph_r;
    if (fast_cnt_r == FAST_HALF - 1) begin
      fast_cnt_nxt = '0;
      fast_ph_nxt  = !fast_ph_r;
    end
    holdup_exp     = (holdup_cnt_r == HOLDUP);
    holdup_cnt_nxt = holdup_cnt_r;
    if (in_ok_s)
      holdup_cnt_nxt = '0;
    else if (!holdup_exp)
      holdup_cnt_nxt = holdup_cnt_r + 32'h1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slow_cnt_r   <= '0;
      fast_cnt_r   <= '0;
      slow_ph_r    <= 1'b0;
      fast_ph_r    <= 1'b0;
      holdup_cnt_r <= '0;
    end else begin
      slow_cnt_r   <= slow_cnt_nxt;
      fast_cnt_r   <= fast_cnt_nxt;
      slow_ph_r    <= slow_ph_nxt;
      fast_ph_r    <= fast_ph_nxt;
      holdup_cnt_r <= holdup_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // fault latches, output control, led
  logic       en_n_d_r, en_rise, clr, inlet_warn, temp_warn, temp_alert;
  logic       main_on_nxt, pg_nxt, conn_nxt, master_nxt, fan_nxt;
  logic [9:0] trim_nxt;
  latch_t     set_v;

  always_comb begin
    en_rise    = en_n_s && !en_n_d_r;
    clr        = en_rise || !in_ok_s;
    set_v      = '{sense_short: mon_s_r.sense_short, ov_main: mon_s_r.ov_main,
                   uv_main: mon_s_r.uv_main, oc_main: mon_s_r.oc_main,
                   fan_fail: mon_s_r.fan_fail, temp_shdn: mon_s_r.temp_shdn};
    // a new fault wins over a clear in the same cycle
    latch_nxt  = latch_t'((latch_r & ~{6{clr}}) | set_v);
    shutdown_nxt = |latch_nxt;
    inlet_warn = inlet_r >= (ctrl_r[CTRL_REV] ? INLET_WARN_REV : INLET_WARN_NORM);
    temp_warn  = inlet_warn || mon_s_r.hot_warn;
    fan_nxt    = temp_warn || mon_s_r.temp_shdn;
    temp_alert = temp_warn && fan_full_speed;
    warn_any   = temp_alert || mon_s_r.fan_slow || mon_s_r.gen_fail;
    // input loss is ridden through until the holdup timer expires
    main_on_nxt = !en_n_s && !kill_s && !shutdown_nxt && !holdup_exp;
    pg_nxt     = main_on_nxt && mon_s_r.main_in_reg && mon_s_r.sb_in_reg;
    conn_nxt   = main_on_nxt && !mon_s_r.gen_fail;
    master_nxt = conn_nxt && largest_s;
    trim_nxt   = '0;
    if (conn_nxt && !largest_s)
      trim_nxt = (trim_req_r > MAX_TRIM_MV) ? MAX_TRIM_MV : trim_req_r;
    if (shutdown_nxt)
      led_nxt = LED_AMBER;
    else if (!in_ok_s)
      led_nxt = LED_OFF;
    else if (ctrl_r[CTRL_SLEEP] || ctrl_r[CTRL_FWUPD])
      led_nxt = LED_FAST;
    else if (!main_on_nxt)
      led_nxt = LED_SLOW;
    else if (pg_nxt)
      led_nxt = LED_GREEN;
    else
      led_nxt = LED_OFF;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      en_n_d_r              <= 1'b1;
      latch_r               <= '0;
      led_r                 <= LED_OFF;
      main_output_on        <= 1'b0;
      standby_on            <= 1'b1;
      power_good            <= 1'b0;
      input_in_range        <= 1'b0;
      fault_alert_n         <= 1'b1;
      present_n             <= 1'b0;
      fan_full_speed        <= 1'b0;
      share_bus_pin_connect <= 1'b0;
      share_master          <= 1'b0;
      share_trim_mv         <= '0;
      led_green             <= 1'b0;
      led_amber             <= 1'b0;
    end else begin
      en_n_d_r              <= en_n_s;
      latch_r               <= latch_nxt;
      led_r                 <= led_nxt;
      main_output_on        <= main_on_nxt;
      standby_on            <= 1'b1;
      power_good            <= pg_nxt;
      input_in_range        <= in_ok_s;
      fault_alert_n         <= !(shutdown_nxt || warn_any);
      present_n             <= 1'b0;
      fan_full_speed        <= fan_nxt;
      share_bus_pin_connect <= conn_nxt;
      share_master          <= master_nxt;
      share_trim_mv         <= trim_nxt;
      led_green             <= (led_nxt == LED_GREEN) || (led_nxt == LED_SLOW && slow_ph_nxt)
                               || (led_nxt == LED_FAST && fast_ph_nxt);
      led_amber             <= (led_nxt == LED_AMBER);
    end
  end

  assign status_w = {19'h0, led_r, share_master, share_bus_pin_connect, fan_full_speed,
                     !fault_alert_n, input_in_range, power_good, main_output_on, standby_on};
  assign fault_w  = {15'h0, mon_s_r.fan_slow, mon_s_r.gen_fail, mon_s_r.hot_warn, inlet_warn,
                     7'h0, latch_r};

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_kill_drop:    assert property (kill_s |=> !main_output_on)
    else $error("main on while kill high");
  chk_standby_on:   assert property ($past(rst_n) |-> standby_on)
    else $error("standby dropped");
  chk_enable_gate:  assert property (main_output_on |-> $past(!en_n_s && !holdup_exp))
    else $error("main on without enable");
  chk_toggle_clr:   assert property (en_rise && set_v == '0 |=> latch_r == '0)
    else $error("latch not cleared by toggle");
  chk_sense_shdn:   assert property (mon_s_r.sense_short |=> !main_output_on ##1 !main_output_on)
    else $error("sense short no shutdown");
  chk_pg_reg:       assert property (power_good |-> $past(mon_s_r.main_in_reg && mon_s_r.sb_in_reg))
    else $error("power good out of regulation");
  chk_pg_holdup:    assert property (holdup_exp |=> !power_good)
    else $error("power good after holdup");
  chk_alert_or:     assert property ((shutdown_nxt || warn_any) |=> !fault_alert_n)
    else $error("alert missing");
  chk_amber_alert:  assert property (led_amber |-> !fault_alert_n)
    else $error("amber without alert");
  chk_fan_first:    assert property ($rose(temp_alert) |-> $past(fan_nxt))
    else $error("alert before fan max");
  chk_present_low:  assert property (!present_n)
    else $error("presence not low");
  chk_share_off:    assert property ((shutdown_nxt || !main_on_nxt) |=> !share_bus_pin_connect)
    else $error("share pin connected while off");
  chk_trim_limit:   assert property (share_trim_mv <= MAX_TRIM_MV && !(share_master && share_trim_mv != '0))
    else $error("trim out of limit");
  chk_ov_hold:      assert property (latch_r.ov_main && !clr |=> latch_r.ov_main && !main_output_on)
    else $error("ov latch lost");
  chk_blink_duty:   assert property ($changed(slow_ph_r) |-> $past(slow_cnt_r) == SLOW_HALF - 1)
    else $error("slow blink period wrong");

endmodule

// ### rtl/psu_sig_pkg.sv
package psu_sig_pkg;

  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned SLOW_BLINK_MHZ = 500;
  localparam int unsigned FAST_BLINK_MHZ = 2000;
  localparam int unsigned SLOW_HALF_CYC  = 32'((64'(CLK_HZ) * 64'd1000) / (64'd2 * SLOW_BLINK_MHZ));
  localparam int unsigned FAST_HALF_CYC  = 32'((64'(CLK_HZ) * 64'd1000) / (64'd2 * FAST_BLINK_MHZ));
  localparam int unsigned HOLDUP_MS      = 10;
  localparam int unsigned HOLDUP_CYC     = (CLK_HZ / 1000) * HOLDUP_MS;

  // inlet temperature in half degrees
  localparam logic [8:0] INLET_WARN_NORM = 9'h073;
  localparam logic [8:0] INLET_WARN_REV  = 9'h07C;
  localparam logic [9:0] MAX_TRIM_MV     = 10'h0FA;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_INLET  = 8'h04;
  localparam logic [7:0] ADDR_TRIM   = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_FAULT  = 8'h10;

  localparam int unsigned CTRL_SLEEP = 0;
  localparam int unsigned CTRL_FWUPD = 1;
  localparam int unsigned CTRL_REV   = 2;

  localparam logic [2:0] CTRL_RST  = 3'h0;
  localparam logic [8:0] INLET_RST = 9'h000;
  localparam logic [9:0] TRIM_RST  = 10'h000;

  typedef struct packed {
    logic sense_short;
    logic ov_main;
    logic uv_main;
    logic oc_main;
    logic fan_fail;
    logic temp_shdn;
    logic hot_warn;
    logic fan_slow;
    logic gen_fail;
    logic main_in_reg;
    logic sb_in_reg;
  } mon_t;

  // latched shutdown causes, order as in fault register
  typedef struct packed {
    logic sense_short;
    logic ov_main;
    logic uv_main;
    logic oc_main;
    logic fan_fail;
    logic temp_shdn;
  } latch_t;

  typedef enum logic [4:0] {
    LED_OFF   = 5'h01,
    LED_GREEN = 5'h02,
    LED_SLOW  = 5'h04,
    LED_FAST  = 5'h08,
    LED_AMBER = 5'h10
  } led_t;

endpackage

// ### test/board_ctl_model.sv
`timescale 1ns/1ns
module board_ctl_model (
  input  wire logic en_req,
  input  wire logic unplug,
  input  wire logic present_n,
  output logic      hot_unplug_kill,
  output logic      main_output_enable_n,
  output logic      slot_filled
);
  // enable is open collector: a released line sits at the pull-up, so the main output is off
  assign main_output_enable_n = en_req ? 1'b0 : 1'b1;
  // kill contact is grounded on the board until the trailing pin breaks on removal
  assign hot_unplug_kill = unplug;
  // board pull-up on the presence line: low reads as a seated supply
  assign slot_filled = ~present_n;
endmodule

// ### test/psu_status_and_control_signals_tb.sv
`timescale 1ns/1ns
module psu_status_and_control_signals_tb;
  import psu_sig_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, ek;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        input_ok_raw, share_largest, en_req, unplug, slot_filled;
  logic        hot_unplug_kill, main_output_enable_n;
  mon_t        mon_raw;
  logic        main_output_on, standby_on, power_good, input_in_range, fault_alert_n;
  logic        present_n, fan_full_speed, share_bus_pin_connect, share_master;
  logic        led_green, led_amber;
  logic [9:0]  share_trim_mv;
  int          err_total, checks_done, cyc, i, n;
  int          rv[4] = '{0, 0, 4, 4};
  int          tp[4] = '{114, 115, 123, 124};
  int          ex[4] = '{1, 0, 1, 0};

  psu_sig_ctrl #(.SLOW_HALF(8), .FAST_HALF(4), .HOLDUP(20)) dut_u (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .hot_unplug_kill, .main_output_enable_n, .input_ok_raw, .share_largest, .mon_raw,
    .main_output_on, .standby_on, .power_good, .input_in_range, .fault_alert_n, .present_n,
    .fan_full_speed, .share_bus_pin_connect, .share_master, .share_trim_mv, .led_green,
    .led_amber);

  board_ctl_model board_u (.en_req, .unplug, .present_n, .hot_unplug_kill,
    .main_output_enable_n, .slot_filled);

  ////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  task automatic close_out();
    if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic w(input int c);
    repeat (c) @(posedge clk);
  endtask

  // one apb transfer; returns at the edge that sampled pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    ek = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  // release then reassert the enable line to clear latches
  task automatic tog();
    en_req <= 1'b0;
    w(6);
    en_req <= 1'b1;
    w(6);
  endtask

  task automatic blinks(output int t);
    logic p;
    t = 0;
    p = led_green;
    repeat (64) begin
      @(posedge clk);
      if (led_green !== p) t++;
      p = led_green;
    end
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; mon_raw = '0; input_ok_raw = 1'b0; share_largest = 1'b0;
    en_req = 1'b0; unplug = 1'b0;
    w(2);
    rst_n <= 1'b1;
    w(1);
    chk("standby", 32'h1, standby_on);
    chk("slot", 32'h1, slot_filled);
    chk("alert_n", 32'h1, fault_alert_n);
    rdc(ADDR_CTRL, {29'h0, CTRL_RST}, "ctrl");
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, ek);
    mon_raw <= mon_t'(11'h003);
    input_ok_raw <= 1'b1;
    en_req <= 1'b1;
    w(6);
    chk("main_on", 32'h1, main_output_on);
    chk("pgood", 32'h1, power_good);
    chk("in_range", 32'h1, input_in_range);
    chk("share_conn", 32'h1, share_bus_pin_connect);
    chk("green", 32'h1, led_green);
    rdc(ADDR_STATUS, 32'h0000024F, "status");
    share_largest <= 1'b1;
    w(6);
    chk("master", 32'h1, share_master);
    share_largest <= 1'b0;
    apb(1'b1, ADDR_TRIM, 32'h1FF);
    w(6);
    chk("trim", {22'h0, MAX_TRIM_MV}, share_trim_mv);
    unplug <= 1'b1;
    w(6);
    chk("main_on", 32'h0, main_output_on);
    chk("standby", 32'h1, standby_on);
    chk("share_conn", 32'h0, share_bus_pin_connect);
    unplug <= 1'b0;
    w(6);
    mon_raw.ov_main <= 1'b1;
    w(6);
    mon_raw.ov_main <= 1'b0;
    w(6);
    chk("main_on", 32'h0, main_output_on);
    chk("amber", 32'h1, led_amber);
    chk("alert_n", 32'h0, fault_alert_n);
    rdc(ADDR_FAULT, 32'h10, "fault");
    tog();
    chk("main_on", 32'h1, main_output_on);
    for (i = 2; i <= 10; i++) begin
      mon_raw[i] <= 1'b1;
      w(6);
      chk("alert_n", 32'h0, fault_alert_n);
      chk("main_on", {31'h0, 1'(i < 5)}, main_output_on);
      mon_raw[i] <= 1'b0;
      tog();
      chk("alert_n", 32'h1, fault_alert_n);
    end
    apb(1'b1, ADDR_INLET, 32'h73);
    n = 0;
    while (fan_full_speed !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk("fan", 32'h1, fan_full_speed);
    chk("alert_n", 32'h1, fault_alert_n);
    w(3);
    chk("alert_n", 32'h0, fault_alert_n);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_CTRL, 32'(rv[i]));
      apb(1'b1, ADDR_INLET, 32'(tp[i]));
      w(6);
      chk("alert_n", 32'(ex[i]), fault_alert_n);
    end
    apb(1'b1, ADDR_INLET, 32'h0);
    for (i = 0; i < 3; i++) begin
      apb(1'b1, ADDR_CTRL, 32'(i));
      en_req <= (i == 1);
      w(8);
      blinks(n);
      chk("blinks", (i == 0) ? 32'd8 : 32'd16, 32'(n));
    end
    apb(1'b1, ADDR_CTRL, 32'h0);
    en_req <= 1'b1;
    w(6);
    input_ok_raw <= 1'b0;
    w(8);
    chk("pgood", 32'h1, power_good);
    w(30);
    chk("pgood", 32'h0, power_good);
    chk("in_range", 32'h0, input_in_range);
    chk("leds", 32'h0, {30'h0, led_green, led_amber});
    close_out();
  end
endmodule
